/* pkg/fbmc_params.svh */
`ifndef FBMC_PARAMS_SVH
`define FBMC_PARAMS_SVH

// Selector encodings
`define FBMC_SEL_HALT 2'h0
`define FBMC_SEL_GO 2'h1
`define FBMC_SEL_CARD 2'h2

// Card actions in card position
`define FBMC_ACT_NONE 2'h0
`define FBMC_ACT_COPY 2'h1
`define FBMC_ACT_SERIAL 2'h2
`define FBMC_ACT_RESET 2'h3

// Alarm classes
`define FBMC_ALM_PROCESS 2'h1
`define FBMC_ALM_DIAG 2'h2
`define FBMC_ALM_SLAVE 2'h3

// Bus limits
`define FBMC_MAX_SLAVES 7'h7D
`define FBMC_SLAVE_W 7
`define FBMC_IO_BYTES_NEW 11'h400
`define FBMC_IO_BYTES_OLD 11'h100
`define FBMC_FW_NEW_MAJOR 4'h3

// Fallback bus parameters
`define FBMC_DEF_ADDR 7'h01
`define FBMC_BAUD_1M5 4'h6

// Card lamp blink
`define FBMC_BLINK_MS 8
`define FBMC_CLK_MHZ 200
`define FBMC_BLINK_CYC (`FBMC_BLINK_MS * `FBMC_CLK_MHZ * 1000)
`define FBMC_BLINK_W 21

// Data path FIFO
`define FBMC_FIFO_W 8
`define FBMC_FIFO_D 8

`endif

/* pkg/fbmc_pkg.sv */
package fbmc_pkg;
  typedef enum logic [2:0] {
    FBMC_BOOT = 3'h0,
    FBMC_LOAD = 3'h1,
    FBMC_LINK = 3'h3,
    FBMC_RUN = 3'h2,
    FBMC_STOP = 3'h6,
    FBMC_CARD = 3'h7
  } fbmc_mode_t;

  typedef struct packed {
    logic active_lamp;
    logic traffic_lamp;
    logic fault_lamp;
    logic param_lamp;
    logic card_lamp;
  } fbmc_lamps_t;

  typedef struct packed {
    logic [1:0] cls;
    logic valid;
  } fbmc_alarm_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [3:0] baud;
    logic use_default;
  } fbmc_busprm_t;
endpackage

/* src/fbmc_fifo.sv */
`timescale 1ns/1ps
module fbmc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic full;
  logic empty;
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty = (wp == rp);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp[AW-1:0]];
  always_ff @(posedge CLK) begin
    if (in_valid && !full) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid && !full) begin
        wp <= wp + 1'b1;
      end
      if (out_ready && !empty) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule

/* src/fbmc_top.sv */
`timescale 1ns/1ps
`include "fbmc_params.svh"
module fbmc_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] SELECTOR,
  input wire logic [1:0] CARD_ACTION,
  input wire logic CARD_PRESENT,
  input wire logic LOAD_DONE,
  input wire logic LOAD_OK,
  input wire logic LINK_OK,
  input wire logic [6:0] SLAVE_COUNT,
  input wire logic ALL_EXCHANGE,
  input wire logic SLAVE_FAIL,
  input wire logic PROCESS_EVENT,
  input wire logic DIAG_EVENT,
  input wire logic OUTPUT_LOCK,
  input wire logic [3:0] FW_MAJOR,
  input wire logic [7:0] OUT_DATA,
  input wire logic OUT_VALID,
  output logic OUT_READY,
  input wire logic [7:0] IN_DATA,
  input wire logic IN_VALID,
  output logic [7:0] LINK_DATA,
  output logic LINK_VALID,
  input wire logic LINK_READY,
  output logic [7:0] IMAGE_DATA,
  output logic IMAGE_VALID,
  output logic LOAD_REQ,
  output logic LOAD_FROM_CARD,
  output logic DROP_HOST_CFG,
  output logic COPY_TO_FLASH,
  output logic SERIAL_MODE,
  output logic OVERALL_RESET,
  output logic POLL_EN,
  output logic OUTPUTS_ZERO,
  output fbmc_pkg::fbmc_busprm_t BUS_PRM,
  output logic [10:0] IO_LIMIT,
  output logic [6:0] SLAVE_LIMIT,
  output fbmc_pkg::fbmc_alarm_t ALARM,
  output fbmc_pkg::fbmc_lamps_t LAMPS
);
  import fbmc_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    fbmc_mode_t mode;
    logic [1:0] sel;
    logic power_on;
    logic from_card;
    logic prm_bad;
    logic fault;
    logic blink;
    logic armed;
    logic [`FBMC_BLINK_W-1:0] blink_cnt;
    logic load_req;
    logic drop_cfg;
    logic copy;
    logic serial;
    logic ovr_reset;
    logic outputs_zero;
    fbmc_busprm_t prm;
    logic [10:0] io_limit;
    logic [6:0] slave_limit;
    fbmc_alarm_t alarm;
    fbmc_lamps_t lamps;
    logic [7:0] image;
    logic image_valid;
  } fbmc_state_t;

  fbmc_state_t s;
  fbmc_state_t next_s;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic link_take;
  logic [7:0] link_word;

  // ------------------------------------------------------------
  // Output data path
  // ------------------------------------------------------------
  fbmc_fifo #(.W(`FBMC_FIFO_W), .D(`FBMC_FIFO_D)) u_fifo (
    .CLK(CLK),
    .RST(RST),
    .in_data(OUT_DATA),
    .in_valid(OUT_VALID),
    .in_ready(OUT_READY),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(link_take)
  );

  // Drain only while polling; lock sends zeros, stop sends nothing
  assign link_take = (s.mode == FBMC_RUN) && LINK_READY;
  assign link_word = s.outputs_zero ? 8'h00 : fifo_out_data;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LINK_DATA <= 8'h00;
      LINK_VALID <= 1'b0;
    end else begin
      LINK_VALID <= link_take && fifo_out_valid;
      LINK_DATA <= (link_take && fifo_out_valid) ? link_word : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sel = SELECTOR;
    next_s.load_req = 1'b0;
    next_s.drop_cfg = 1'b0;
    next_s.copy = 1'b0;
    next_s.serial = 1'b0;
    next_s.ovr_reset = 1'b0;
    next_s.alarm = '0;
    next_s.image_valid = 1'b0;
    next_s.slave_limit = `FBMC_MAX_SLAVES;
    next_s.io_limit = (FW_MAJOR < `FBMC_FW_NEW_MAJOR) ?
      `FBMC_IO_BYTES_OLD : `FBMC_IO_BYTES_NEW;
    next_s.blink_cnt = s.blink_cnt + 1'b1;
    if (s.blink_cnt == `FBMC_BLINK_W'(`FBMC_BLINK_CYC - 1)) begin
      next_s.blink_cnt = '0;
      next_s.blink = !s.blink;
    end
    case (s.mode)
      FBMC_BOOT: begin
        next_s.load_req = 1'b1;
        next_s.mode = FBMC_LOAD;
      end
      FBMC_LOAD: begin
        if (!s.from_card || CARD_PRESENT) begin
          if (LOAD_DONE) begin
            next_s.prm_bad = !LOAD_OK;
            if (LOAD_OK && s.sel == `FBMC_SEL_GO) begin
              next_s.mode = FBMC_LINK;
            end else begin
              next_s.mode = FBMC_STOP;
            end
          end
        end else begin
          next_s.prm_bad = 1'b1;
          next_s.mode = FBMC_STOP;
        end
      end
      FBMC_LINK: begin
        if (s.sel != `FBMC_SEL_GO) begin
          next_s.mode = FBMC_STOP;
        end else if (LINK_OK || s.power_on) begin
          next_s.mode = FBMC_RUN;
        end
      end
      FBMC_RUN: begin
        if (s.sel == `FBMC_SEL_HALT) begin
          next_s.mode = FBMC_STOP;
          next_s.alarm = '{cls: `FBMC_ALM_SLAVE, valid: 1'b1};
        end else if (SLAVE_FAIL && !s.fault) begin
          next_s.alarm = '{cls: `FBMC_ALM_SLAVE, valid: 1'b1};
        end else if (DIAG_EVENT) begin
          next_s.alarm = '{cls: `FBMC_ALM_DIAG, valid: 1'b1};
        end else if (PROCESS_EVENT) begin
          next_s.alarm = '{cls: `FBMC_ALM_PROCESS, valid: 1'b1};
        end
        if (IN_VALID && !SLAVE_FAIL) begin
          next_s.image = IN_DATA;
          next_s.image_valid = 1'b1;
        end
      end
      FBMC_STOP: begin
        // Reboot only on a halt to go move, not after a failed load
        if (s.sel == `FBMC_SEL_HALT) begin
          next_s.armed = 1'b1;
        end
        if (s.sel == `FBMC_SEL_GO && s.armed) begin
          next_s.armed = 1'b0;
          next_s.power_on = 1'b0;
          next_s.from_card = 1'b0;
          next_s.drop_cfg = 1'b1;
          next_s.mode = FBMC_BOOT;
        end else if (s.sel == `FBMC_SEL_CARD) begin
          next_s.mode = FBMC_CARD;
        end
      end
      FBMC_CARD: begin
        case (CARD_ACTION)
          `FBMC_ACT_COPY: next_s.copy = 1'b1;
          `FBMC_ACT_SERIAL: next_s.serial = 1'b1;
          `FBMC_ACT_RESET: next_s.ovr_reset = 1'b1;
          default: next_s.copy = 1'b0;
        endcase
        if (s.sel != `FBMC_SEL_CARD) begin
          next_s.mode = FBMC_STOP;
        end
      end
      default: next_s.mode = FBMC_BOOT;
    endcase
    // Fault set on first RUN after power-on or on slave failure; cleared once all exchange
    if (next_s.mode == FBMC_RUN && s.mode != FBMC_RUN && s.power_on) begin
      next_s.fault = 1'b1;
    end else if (SLAVE_FAIL) begin
      next_s.fault = 1'b1;
    end else if (ALL_EXCHANGE) begin
      next_s.fault = 1'b0;
    end
    // Bus parameters: fallback on bad parameters
    next_s.prm.use_default = next_s.prm_bad;
    if (next_s.prm_bad) begin
      next_s.prm.addr = `FBMC_DEF_ADDR;
      next_s.prm.baud = `FBMC_BAUD_1M5;
    end
    // Outputs forced to zero outside RUN or on lock
    next_s.outputs_zero = (next_s.mode != FBMC_RUN) || OUTPUT_LOCK;
    // Lamps from the next state so the register follows it
    next_s.lamps.active_lamp = (next_s.mode == FBMC_LINK) ||
      (next_s.mode == FBMC_RUN);
    next_s.lamps.traffic_lamp = (next_s.mode == FBMC_RUN) &&
      !next_s.outputs_zero;
    next_s.lamps.fault_lamp = next_s.fault && (next_s.mode == FBMC_RUN ||
      next_s.mode == FBMC_LINK);
    next_s.lamps.param_lamp = next_s.prm_bad;
    next_s.lamps.card_lamp = next_s.prm_bad ||
      ((next_s.mode == FBMC_LOAD) && s.from_card && next_s.blink);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.mode <= FBMC_BOOT;
      s.power_on <= 1'b1;
      s.from_card <= 1'b1;
      s.outputs_zero <= 1'b1;
      s.prm.addr <= `FBMC_DEF_ADDR;
      s.prm.baud <= `FBMC_BAUD_1M5;
      s.io_limit <= `FBMC_IO_BYTES_NEW;
      s.slave_limit <= `FBMC_MAX_SLAVES;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign IMAGE_DATA = s.image;
  assign IMAGE_VALID = s.image_valid;
  assign LOAD_REQ = s.load_req;
  assign LOAD_FROM_CARD = s.from_card;
  assign DROP_HOST_CFG = s.drop_cfg;
  assign COPY_TO_FLASH = s.copy;
  assign SERIAL_MODE = s.serial;
  assign OVERALL_RESET = s.ovr_reset;
  assign POLL_EN = (s.mode == FBMC_RUN);
  assign OUTPUTS_ZERO = s.outputs_zero;
  assign BUS_PRM = s.prm;
  assign IO_LIMIT = s.io_limit;
  assign SLAVE_LIMIT = s.slave_limit;
  assign ALARM = s.alarm;
  assign LAMPS = s.lamps;
endmodule

/* tb/fbmc_checker.sv */
`timescale 1ns/1ps
// ---
// Port checks
// ---
module fbmc_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] SELECTOR,
  input wire logic SLAVE_FAIL,
  input wire logic OUTPUT_LOCK,
  input wire logic [3:0] FW_MAJOR,
  input wire logic IMAGE_VALID,
  input wire logic POLL_EN,
  input wire logic OUTPUTS_ZERO,
  input wire fbmc_pkg::fbmc_busprm_t BUS_PRM,
  input wire logic [10:0] IO_LIMIT,
  input wire logic [6:0] SLAVE_LIMIT,
  input wire fbmc_pkg::fbmc_alarm_t ALARM,
  input wire fbmc_pkg::fbmc_lamps_t LAMPS
);
  import fbmc_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_lock_zero: assert property (OUTPUT_LOCK |=> OUTPUTS_ZERO)
    else $error("lock ignored");
  a_halt_alarm: assert property (POLL_EN && SELECTOR == 2'h0
    |-> ##[1:3] (ALARM.valid && ALARM.cls == 2'h3))
    else $error("no alarm on halt");
  a_fail_lamp: assert property (POLL_EN && SLAVE_FAIL
    |=> LAMPS.fault_lamp) else $error("fault lamp off");
  a_run_param: assert property (POLL_EN |-> !LAMPS.param_lamp)
    else $error("run with bad parameters");
  a_traffic_act: assert property (LAMPS.traffic_lamp
    |-> LAMPS.active_lamp) else $error("traffic without active");
  a_default_prm: assert property (BUS_PRM.use_default
    |-> BUS_PRM.addr == 7'h01 && BUS_PRM.baud == 4'h6)
    else $error("default bus parameters wrong");
  a_fail_image: assert property (SLAVE_FAIL |=> !IMAGE_VALID)
    else $error("image updated after failure");
  a_io_old: assert property (FW_MAJOR < 4'h3
    |=> IO_LIMIT == 11'h100) else $error("old limit wrong");
  a_slave_max: assert property (SLAVE_LIMIT == 7'h7D)
    else $error("slave limit wrong");
endmodule
bind fbmc_top fbmc_checker chk_u (.CLK, .RST, .SELECTOR, .SLAVE_FAIL,
  .OUTPUT_LOCK, .FW_MAJOR, .IMAGE_VALID, .POLL_EN, .OUTPUTS_ZERO,
  .BUS_PRM, .IO_LIMIT, .SLAVE_LIMIT, .ALARM, .LAMPS);

/* tb/fbmc_slave_model.sv */
`timescale 1ns/1ps
// ---
// Slave side of the link
// ---
module fbmc_slave_model #(
  parameter int STATION = 3
) (
  input wire logic clk,
  input wire logic stall,
  input wire logic [7:0] link_data,
  input wire logic link_valid,
  input wire logic poll_en,
  output logic link_ready,
  output logic [7:0] in_data,
  output logic in_valid
);
  logic [7:0] got [$];
  initial begin
    link_ready = 1'b0;
    in_data = 8'h00;
    in_valid = 1'b0;
  end
  always @(posedge clk) begin
    // Each valid pulse carries a byte already taken on ready
    if (link_valid) got.push_back(link_data);
    link_ready <= !stall;
    in_valid <= poll_en;
    // Idle line alternates each cycle between last byte and its inverse
    in_data <= poll_en ? in_data + 8'h01 : ~in_data;
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
// ---
// Mode controller bench
// ---
module testbench;
  import fbmc_pkg::*;
  logic CLK, RST, card, ldone, lok, link_ok, all_ex, fail, pev, dev;
  logic lock, oval, ordy, lv, lr, ival, lreq, lcard, drop, cp, sm, ovr;
  logic poll, oz, hold, stall, req_card;
  logic [1:0] sel, act, last_cls;
  logic [3:0] fw;
  logic [7:0] odata, ld, idata;
  logic [6:0] slim;
  logic [10:0] iol;
  fbmc_busprm_t prm;
  fbmc_alarm_t alm;
  fbmc_lamps_t lamps;
  logic [7:0] exp_q [$];
  int num_errors, samples_checked, cyc, ndrop, n, seed;
  fbmc_top dut_u (.CLK(CLK), .RST(RST), .SELECTOR(sel),
    .CARD_ACTION(act), .CARD_PRESENT(card), .LOAD_DONE(ldone),
    .LOAD_OK(lok), .LINK_OK(link_ok), .SLAVE_COUNT(7'h7D),
    .ALL_EXCHANGE(all_ex), .SLAVE_FAIL(fail), .PROCESS_EVENT(pev),
    .DIAG_EVENT(dev), .OUTPUT_LOCK(lock), .FW_MAJOR(fw),
    .OUT_DATA(odata), .OUT_VALID(oval), .OUT_READY(ordy),
    .IN_DATA(idata), .IN_VALID(ival), .LINK_DATA(ld), .LINK_VALID(lv),
    .LINK_READY(lr), .IMAGE_DATA(), .IMAGE_VALID(), .LOAD_REQ(lreq),
    .LOAD_FROM_CARD(lcard), .DROP_HOST_CFG(drop), .COPY_TO_FLASH(cp),
    .SERIAL_MODE(sm), .OVERALL_RESET(ovr), .POLL_EN(poll),
    .OUTPUTS_ZERO(oz), .BUS_PRM(prm), .IO_LIMIT(iol), .SLAVE_LIMIT(slim),
    .ALARM(alm), .LAMPS(lamps));
  fbmc_slave_model slv_u (.clk(CLK), .stall(stall), .link_data(ld),
    .link_valid(lv), .poll_en(poll), .link_ready(lr), .in_data(idata),
    .in_valid(ival));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic give_verdict();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [4:0] lamp_exp(input logic [4:0] on);
    return on;
  endfunction
  function automatic logic [2:0] act_exp(input logic [1:0] a);
    return 3'h4 >> (a - 2'h1);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask
  task automatic wait_poll(input logic v);
    for (int i = 0; i < 100 && poll !== v; i++) tick(1);
    chk(12'(poll), 12'(v));
  endtask
  // ---
  // Load responder, alarm capture, timeout
  // ---
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    fw <= 4'($random(seed));
    stall <= hold | 1'($random(seed));
    ldone <= lreq;
    if (alm.valid) last_cls <= alm.cls;
    if (lreq) req_card <= lcard;
    if (drop) ndrop <= ndrop + 1;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    seed = 32'hc17c;
    {RST, hold, card, lok, sel} = 6'h3D;
    {link_ok, all_ex, fail, pev, dev, lock, oval, req_card} = 8'h00;
    {act, last_cls, fw, odata, stall} = 17'h0C001;
    tick(20);
    RST <= 1'b0;
    wait_poll(1'b1);
    chk(12'(req_card), 12'h1);
    chk(12'(slim), 12'h07D);
    tick(2);
    chk(12'(lamps), 12'(lamp_exp(5'h1C)));
    @(posedge CLK);
    all_ex <= 1'b1;
    tick(3);
    chk(12'(lamps.fault_lamp), 12'h0);
    @(posedge CLK);
    oval <= 1'b1;
    odata <= 8'($random(seed));
    #1;
    while (ordy === 1'b1 && n < 20) begin
      exp_q.push_back(odata);
      n++;
      @(posedge CLK);
      odata <= 8'($random(seed));
      #1;
    end
    chk(12'(n), 12'h8);
    @(posedge CLK);
    oval <= 1'b0;
    hold <= 1'b0;
    for (n = 0; n < 400 && slv_u.got.size() < 8; n++) tick(1);
    foreach (exp_q[i]) chk(12'(slv_u.got[i]), 12'(exp_q[i]));
    @(posedge CLK);
    lock <= 1'b1;
    tick(3);
    chk(12'(oz), 12'h1);
    chk(12'(lamps), 12'(lamp_exp(5'h10)));
    @(posedge CLK);
    lock <= 1'b0;
    fail <= 1'b1;
    tick(3);
    chk(12'(lamps.fault_lamp), 12'h1);
    chk(12'(last_cls), 12'h3);
    @(posedge CLK);
    fail <= 1'b0;
    for (n = 1; n < 3; n++) begin
      @(posedge CLK);
      pev <= (n == 1);
      dev <= (n == 2);
      @(posedge CLK);
      {pev, dev} <= 2'h0;
      tick(3);
      chk(12'(last_cls), 12'(n));
    end
    @(posedge CLK);
    sel <= 2'h0;
    last_cls <= 2'h0;
    tick(4);
    chk(12'(poll), 12'h0);
    chk(12'(last_cls), 12'h3);
    chk(12'(oz), 12'h1);
    chk(12'(prm.use_default), 12'h0);
    @(posedge CLK);
    sel <= 2'h2;
    for (n = 1; n < 4; n++) begin
      @(posedge CLK);
      act <= 2'(n);
      tick(3);
      chk(12'({cp, sm, ovr}), 12'(act_exp(2'(n))));
    end
    @(posedge CLK);
    act <= 2'h0;
    sel <= 2'h0;
    tick(3);
    sel <= 2'h1;
    tick(8);
    chk(12'(ndrop), 12'h1);
    chk(12'(req_card), 12'h0);
    chk(12'(lamps), 12'(lamp_exp(5'h10)));
    @(posedge CLK);
    link_ok <= 1'b1;
    wait_poll(1'b1);
    tick(2);
    chk(12'(lamps.traffic_lamp), 12'h1);
    @(posedge CLK);
    sel <= 2'h0;
    link_ok <= 1'b0;
    tick(4);
    lok <= 1'b0;
    sel <= 2'h1;
    tick(8);
    chk(12'(poll), 12'h0);
    chk(12'(lamps.param_lamp), 12'h1);
    chk(12'(lamps.card_lamp), 12'h1);
    chk(12'(prm), 12'({7'h01, 4'h6, 1'b1}));
    give_verdict();
  end
endmodule
